// ==== verilog/bsl_pkg.sv ====
// Constants for the buck setpoint and ceiling register bank
package bsl_pkg;

  localparam int unsigned NUM_REGS = 5;
  localparam int unsigned AW       = 8;
  localparam int unsigned DW       = 8;

  // Register indices
  localparam int unsigned IDX_B2_NORMAL = 0;
  localparam int unsigned IDX_B2_SCALED = 1;
  localparam int unsigned IDX_B2_CEIL   = 2;
  localparam int unsigned IDX_B3_NORMAL = 3;
  localparam int unsigned IDX_B3_SCALED = 4;

  // Register offsets
  localparam logic [AW-1:0] OFF_B2_NORMAL = 8'h07;
  localparam logic [AW-1:0] OFF_B2_SCALED = 8'h08;
  localparam logic [AW-1:0] OFF_B2_CEIL   = 8'h09;
  localparam logic [AW-1:0] OFF_B3_NORMAL = 8'h0A;
  localparam logic [AW-1:0] OFF_B3_SCALED = 8'h0B;

  localparam logic [AW-1:0] REG_OFF [NUM_REGS] = '{
    OFF_B2_NORMAL, OFF_B2_SCALED, OFF_B2_CEIL, OFF_B3_NORMAL, OFF_B3_SCALED
  };

  // Implemented bits; the rest read zero and ignore writes
  localparam logic [DW-1:0] MASK_NORMAL = 8'h7F;
  localparam logic [DW-1:0] MASK_FULL   = 8'hFF;

  localparam logic [DW-1:0] REG_MASK [NUM_REGS] = '{
    MASK_NORMAL, MASK_FULL, MASK_FULL, MASK_NORMAL, MASK_FULL
  };

  // Field positions
  localparam int unsigned CODE_W    = 6;
  localparam int unsigned CODE_LSB  = 0;
  localparam int unsigned CODE_MSB  = 5;
  localparam int unsigned SRC_BIT   = 6;
  localparam int unsigned RANGE_W   = 2;
  localparam int unsigned RANGE_LSB = 6;
  localparam int unsigned RANGE_MSB = 7;

  // Ceiling values that leave the ceiling register unlocked
  localparam logic [CODE_W-1:0] CEIL_OPEN_HI = 6'h3F;
  localparam logic [CODE_W-1:0] CEIL_OPEN_LO = 6'h00;

  localparam logic [DW-1:0] RD_IDLE = 8'h00;

endpackage : bsl_pkg

// ==== verilog/bsl_clamp.sv ====
// Setpoint code clamp against a ceiling
module bsl_clamp (
  // Codes
  input  wire logic [5:0] code_i,
  input  wire logic [5:0] ceil_i,
  // Result
  output logic      [5:0] code_o,
  output logic            clamped_o
);

  always_comb begin
    clamped_o = (code_i > ceil_i);
    code_o    = clamped_o ? ceil_i : code_i;
  end

endmodule // bsl_clamp

// ==== verilog/bsl_top.sv ====
// Buck2 ceiling and buck3 setpoint register bank with effective code outputs
module bsl_top (
  // Clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  output logic      [7:0] rd_data_o,
  // One-time-programmed defaults
  input  wire logic [7:0] otp_buck2_normal_i,
  input  wire logic [7:0] otp_buck2_scaled_i,
  input  wire logic [7:0] otp_buck2_ceiling_i,
  input  wire logic [7:0] otp_buck3_normal_i,
  input  wire logic [7:0] otp_buck3_scaled_i,
  input  wire logic [1:0] otp_buck3_range_i,
  // Pins
  input  wire logic       config_strap_pin_i,
  input  wire logic       buck3_setpoint_select_pin_i,
  // Converter side
  output logic      [1:0] buck2_range_o,
  output logic      [5:0] buck2_code_o,
  output logic            buck2_clamped_o,
  output logic            buck2_locked_o,
  output logic      [1:0] buck3_range_o,
  output logic      [5:0] buck3_code_o,
  output logic            buck3_use_scaled_o
);

  logic [7:0] regs_q [bsl_pkg::NUM_REGS];
  logic [7:0] otp_w  [bsl_pkg::NUM_REGS];
  logic [bsl_pkg::NUM_REGS-1:0] wr_hit_w;
  logic [bsl_pkg::NUM_REGS-1:0] rd_hit_w;
  logic [7:0] rd_d;
  logic [5:0] ceil_w;
  logic       locked_w;
  logic       b2_src_w;
  logic [5:0] b2_raw_w;
  logic [5:0] b2_clamp_w;
  logic       b2_clamped_w;
  logic       b3_use_scaled_d;
  logic [5:0] b3_code_d;
  logic [1:0] b3_range_q;
  logic       rst_dly_q;
  logic       chk_off_w;

  assign otp_w[bsl_pkg::IDX_B2_NORMAL] = otp_buck2_normal_i;
  assign otp_w[bsl_pkg::IDX_B2_SCALED] = otp_buck2_scaled_i;
  assign otp_w[bsl_pkg::IDX_B2_CEIL]   = otp_buck2_ceiling_i;
  assign otp_w[bsl_pkg::IDX_B3_NORMAL] = otp_buck3_normal_i;
  assign otp_w[bsl_pkg::IDX_B3_SCALED] = otp_buck3_scaled_i;

  // Ceiling lock state
  assign ceil_w   = regs_q[bsl_pkg::IDX_B2_CEIL][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB];
  assign locked_w = (ceil_w != bsl_pkg::CEIL_OPEN_HI) &&
                    (ceil_w != bsl_pkg::CEIL_OPEN_LO);

  // Register storage, one entry per register
  for (genvar g = 0; g < bsl_pkg::NUM_REGS; g++) begin : g_reg
    assign wr_hit_w[g] = wr_en_i && (addr_i == bsl_pkg::REG_OFF[g]);
    assign rd_hit_w[g] = rd_en_i && (addr_i == bsl_pkg::REG_OFF[g]);

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        regs_q[g] <= otp_w[g] & bsl_pkg::REG_MASK[g];
      end else if (ce_i && wr_hit_w[g] &&
                   !((g == bsl_pkg::IDX_B2_CEIL) && locked_w)) begin
        regs_q[g] <= wr_data_i & bsl_pkg::REG_MASK[g];
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    rd_d = bsl_pkg::RD_IDLE;
    for (int i = 0; i < bsl_pkg::NUM_REGS; i++) begin
      if (rd_hit_w[i]) begin
        rd_d = regs_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= bsl_pkg::RD_IDLE;
    end else if (ce_i) begin
      rd_data_o <= rd_d;
    end
  end

  // Buck2 effective code
  assign b2_src_w = regs_q[bsl_pkg::IDX_B2_NORMAL][bsl_pkg::SRC_BIT];
  assign b2_raw_w = b2_src_w ?
    regs_q[bsl_pkg::IDX_B2_SCALED][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB] :
    regs_q[bsl_pkg::IDX_B2_NORMAL][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB];

  bsl_clamp bsl_clamp_i (
    .code_i    (b2_raw_w),
    .ceil_i    (ceil_w),
    .code_o    (b2_clamp_w),
    .clamped_o (b2_clamped_w)
  );

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      buck2_range_o   <= '0;
      buck2_code_o    <= '0;
      buck2_clamped_o <= 1'b0;
      buck2_locked_o  <= 1'b0;
    end else if (ce_i) begin
      buck2_range_o   <= regs_q[bsl_pkg::IDX_B2_CEIL][bsl_pkg::RANGE_MSB:bsl_pkg::RANGE_LSB];
      buck2_code_o    <= b2_clamp_w;
      buck2_clamped_o <= b2_clamped_w;
      buck2_locked_o  <= locked_w;
    end
  end

  // Buck3 source selection and effective code
  always_comb begin
    b3_use_scaled_d = regs_q[bsl_pkg::IDX_B3_NORMAL][bsl_pkg::SRC_BIT] ||
                      (!config_strap_pin_i && buck3_setpoint_select_pin_i);
    b3_code_d = b3_use_scaled_d ?
      regs_q[bsl_pkg::IDX_B3_SCALED][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB] :
      regs_q[bsl_pkg::IDX_B3_NORMAL][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      b3_range_q <= otp_buck3_range_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      buck3_range_o      <= '0;
      buck3_code_o       <= '0;
      buck3_use_scaled_o <= 1'b0;
    end else if (ce_i) begin
      buck3_range_o      <= b3_range_q;
      buck3_code_o       <= b3_code_d;
      buck3_use_scaled_o <= b3_use_scaled_d;
    end
  end

  // Checks stay off through the edge that leaves reset, whose outputs are still cleared
  always_ff @(posedge sys_clk_i) begin
    rst_dly_q <= rst_i;
  end

  assign chk_off_w = rst_i || rst_dly_q;

  // Assertions
  property p_range_follow;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    ce_i |=> buck2_range_o ==
             $past(regs_q[bsl_pkg::IDX_B2_CEIL][bsl_pkg::RANGE_MSB:bsl_pkg::RANGE_LSB]);
  endproperty
  a_range_follow: assert property (p_range_follow)
    else $error("Buck2 range output does not follow range field");

  property p_code_below_ceiling;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    ce_i |=> buck2_code_o <= $past(ceil_w);
  endproperty
  a_code_below_ceiling: assert property (p_code_below_ceiling)
    else $error("Buck2 code exceeds ceiling");

  property p_clamp_substitute;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && (b2_raw_w > ceil_w)) |=> (buck2_code_o == $past(ceil_w)) && buck2_clamped_o;
  endproperty
  a_clamp_substitute: assert property (p_clamp_substitute)
    else $error("Over-ceiling code not replaced by ceiling");

  property p_pass_through;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && (b2_raw_w <= ceil_w)) |=> (buck2_code_o == $past(b2_raw_w)) && !buck2_clamped_o;
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("In-range buck2 code altered");

  property p_lock_blocks;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (locked_w && wr_en_i && (addr_i == bsl_pkg::OFF_B2_CEIL))
      |=> $stable(regs_q[bsl_pkg::IDX_B2_CEIL]) ##1 (buck2_locked_o || !$past(ce_i));
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("Locked ceiling register changed by a write");

  property p_open_write;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (!locked_w && ce_i && wr_en_i && (addr_i == bsl_pkg::OFF_B2_CEIL))
      |=> regs_q[bsl_pkg::IDX_B2_CEIL] == $past(wr_data_i);
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("Open ceiling register did not take a write");

  property p_lock_flag;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    ce_i |=> buck2_locked_o == $past((ceil_w != bsl_pkg::CEIL_OPEN_HI) &&
                                     (ceil_w != bsl_pkg::CEIL_OPEN_LO));
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("Buck2 lock flag does not match ceiling value");

  property p_otp_load;
    @(posedge sys_clk_i)
    $fell(rst_i) |-> (regs_q[bsl_pkg::IDX_B2_CEIL] == $past(otp_buck2_ceiling_i)) &&
                     (regs_q[bsl_pkg::IDX_B3_SCALED] == $past(otp_buck3_scaled_i));
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("Register not loaded from programmed default at reset");

  property p_b3_range_load;
    @(posedge sys_clk_i)
    $fell(rst_i) |-> b3_range_q == $past(otp_buck3_range_i);
  endproperty
  a_b3_range_load: assert property (p_b3_range_load)
    else $error("Buck3 range not loaded from programmed default at reset");

  property p_select;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    ce_i |=> buck3_use_scaled_o == $past(regs_q[bsl_pkg::IDX_B3_NORMAL][bsl_pkg::SRC_BIT] ||
                                        (!config_strap_pin_i && buck3_setpoint_select_pin_i));
  endproperty
  a_select: assert property (p_select)
    else $error("Buck3 source selection wrong");

  property p_b3_code;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i ##1 ce_i) |-> buck3_use_scaled_o ?
      (buck3_code_o ==
       $past(regs_q[bsl_pkg::IDX_B3_SCALED][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB])) :
      (buck3_code_o ==
       $past(regs_q[bsl_pkg::IDX_B3_NORMAL][bsl_pkg::CODE_MSB:bsl_pkg::CODE_LSB]));
  endproperty
  a_b3_code: assert property (p_b3_code)
    else $error("Buck3 code not taken from selected register");

  property p_rsvd_zero;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && rd_en_i && (addr_i == bsl_pkg::OFF_B3_NORMAL)) |=> !rd_data_o[bsl_pkg::DW-1];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Buck3 normal setpoint top bit reads one");

  property p_rsvd_write;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && wr_en_i && (addr_i == bsl_pkg::OFF_B3_NORMAL))
      |=> regs_q[bsl_pkg::IDX_B3_NORMAL] == ($past(wr_data_i) & bsl_pkg::MASK_NORMAL);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("Buck3 normal setpoint top bit took a write");

  property p_rd_ceiling;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && rd_en_i && (addr_i == bsl_pkg::OFF_B2_CEIL))
      |=> rd_data_o == $past(regs_q[bsl_pkg::IDX_B2_CEIL]);
  endproperty
  a_rd_ceiling: assert property (p_rd_ceiling)
    else $error("Ceiling register read data wrong");

  property p_rd_idle;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    (ce_i && !rd_en_i) |=> rd_data_o == bsl_pkg::RD_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data not idle without read strobe");

  property p_ce_freeze;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    !ce_i |=> $stable(buck2_code_o) && $stable(buck3_code_o) && $stable(rd_data_o) &&
              $stable(regs_q[bsl_pkg::IDX_B3_SCALED]);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("State changed while clock enable low");

  property p_cov_locked_write;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    locked_w && wr_en_i && (addr_i == bsl_pkg::OFF_B2_CEIL);
  endproperty
  c_locked_write: cover property (p_cov_locked_write);

  property p_cov_clamp;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    buck2_clamped_o;
  endproperty
  c_clamp: cover property (p_cov_clamp);

  property p_cov_pin_select;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    !config_strap_pin_i && buck3_setpoint_select_pin_i ##1 buck3_use_scaled_o;
  endproperty
  c_pin_select: cover property (p_cov_pin_select);

  property p_cov_otp_lock;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    $fell(rst_i) ##1 buck2_locked_o;
  endproperty
  c_otp_lock: cover property (p_cov_otp_lock);

  property p_cov_frozen_write;
    @(posedge sys_clk_i) disable iff (chk_off_w)
    !ce_i && wr_en_i;
  endproperty
  c_frozen_write: cover property (p_cov_frozen_write);

endmodule // bsl_top

// ==== test/bsl_top_bench.sv ====
// Self-checking bench for the buck setpoint and ceiling register bank
module bsl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic       wr_en_i = 1'b0;
  logic       rd_en_i = 1'b0;
  logic [7:0] rd_data_o;
  logic       config_strap_pin_i = 1'b1;
  logic       buck3_setpoint_select_pin_i = 1'b0;
  logic [7:0] otp_buck2_ceiling_i = 8'hBF;
  logic [1:0] buck2_range_o;
  logic [5:0] buck2_code_o;
  logic       buck2_clamped_o;
  logic       buck2_locked_o;
  logic [1:0] buck3_range_o;
  logic [5:0] buck3_code_o;
  logic       buck3_use_scaled_o;
  int         miscompares = 0;
  int         n_compared = 0;
  int         cycles = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  bsl_top bsl_top_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .otp_buck2_normal_i(8'hA5), .otp_buck2_scaled_i(8'h3C),
    .otp_buck2_ceiling_i(otp_buck2_ceiling_i),
    .otp_buck3_normal_i(8'h96), .otp_buck3_scaled_i(8'h2C), .otp_buck3_range_i(2'b10),
    .config_strap_pin_i(config_strap_pin_i),
    .buck3_setpoint_select_pin_i(buck3_setpoint_select_pin_i),
    .buck2_range_o(buck2_range_o), .buck2_code_o(buck2_code_o),
    .buck2_clamped_o(buck2_clamped_o), .buck2_locked_o(buck2_locked_o),
    .buck3_range_o(buck3_range_o), .buck3_code_o(buck3_code_o),
    .buck3_use_scaled_o(buck3_use_scaled_o)
  );

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared = n_compared + 1;
    if (exp !== got) begin
      miscompares = miscompares + 1;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i   <= 1'b0;
    settle();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk("rd_data", exp, rd_data_o);
    @(posedge sys_clk_i);
    #1;
    chk("rd_idle", 8'h00, rd_data_o);
  endtask

  task automatic b2(input logic [7:0] rc, input logic [1:0] fl);
    chk("buck2_range_code", rc, {buck2_range_o, buck2_code_o});
    chk("buck2_clamp_lock", {6'h00, fl}, {6'h00, buck2_clamped_o, buck2_locked_o});
  endtask

  task automatic b3(input logic [7:0] exp);
    chk("buck3_sel_code", exp, {1'b0, buck3_use_scaled_o, buck3_code_o});
  endtask

  task automatic t_reset_defaults();
    do_reset();
    rd_chk(8'h07, 8'h25);
    rd_chk(8'h08, 8'h3C);
    rd_chk(8'h09, 8'hBF);
    rd_chk(8'h0A, 8'h16);
    rd_chk(8'h0B, 8'h2C);
    rd_chk(8'h20, 8'h00);
    b2(8'hA5, 2'b00);
    chk("buck3_range", 8'h02, {6'h00, buck3_range_o});
  endtask

  task automatic t_ceiling_clamp();
    wr(8'h09, 8'h00);
    b2(8'h00, 2'b10);
    wr(8'h09, 8'h60);
    b2(8'h60, 2'b11);
    wr(8'h07, 8'h40);
    b2(8'h60, 2'b11);
    wr(8'h08, 8'h1F);
    b2(8'h5F, 2'b01);
    wr(8'h08, 8'h20);
    b2(8'h60, 2'b01);
    wr(8'h09, 8'hFF);
    rd_chk(8'h09, 8'h60);
    b2(8'h60, 2'b01);
  endtask

  task automatic set_pins(input logic strap, input logic sel);
    @(posedge sys_clk_i);
    config_strap_pin_i          <= strap;
    buck3_setpoint_select_pin_i <= sel;
    settle();
  endtask

  task automatic t_buck3_select();
    set_pins(1'b1, 1'b1);
    b3(8'h16);
    set_pins(1'b0, 1'b1);
    b3(8'h6C);
    set_pins(1'b0, 1'b0);
    b3(8'h16);
    wr(8'h0A, 8'hC5);
    rd_chk(8'h0A, 8'h45);
    b3(8'h6C);
    wr(8'h0B, 8'h11);
    b3(8'h51);
  endtask

  task automatic t_ce_and_rereset();
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(8'h0B, 8'h22);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rd_chk(8'h0B, 8'h11);
    do_reset();
    rd_chk(8'h09, 8'hBF);
    b2(8'hA5, 2'b00);
    wr(8'h09, 8'h3F);
    b2(8'h25, 2'b00);
    @(posedge sys_clk_i);
    otp_buck2_ceiling_i <= 8'h5A;
    do_reset();
    b2(8'h5A, 2'b11);
    wr(8'h09, 8'h3F);
    rd_chk(8'h09, 8'h5A);
    b2(8'h5A, 2'b11);
  endtask

  initial begin
    t_reset_defaults();
    t_ceiling_clamp();
    t_buck3_select();
    t_ce_and_rereset();
    report_and_stop();
  end

endmodule // bsl_top_bench
